// [design/async_mem_params.svh]
// Purpose: shared constants for the asynchronous memory controller
// Assumes: phase fields are held as (count - 1), so zero means one period
// Notes:   included by the package file; the controller only uses its macros
`ifndef ASYNC_MEM_PARAMS_SVH
`define ASYNC_MEM_PARAMS_SVH

`define AM_NUM_CS        3
`define AM_CS_W          2
`define AM_ADDR_W        22
`define AM_BANK_W        2
`define AM_DATA_W        16
`define AM_BYTE_W        8
`define AM_TA_W          2
`define AM_SETUP_W       4
`define AM_STROBE_W      6
`define AM_HOLD_W        3
`define AM_CNT_W         6
`define AM_MAXWAIT_W     8
`define AM_WAIT_UNIT     16
`define AM_WSUB_W        4
`define AM_WSUB_LAST     4'hf
`define AM_RELEASE_CYC   1
`define AM_CNT_ZERO      6'h00
`define AM_CS_IDLE       3'h7
`define AM_DATA_RST      16'h0000
`define AM_ADDR_RST      22'h000000
`define AM_BANK_RST      2'h0

`endif

// [design/async_mem_pkg.sv]
// Purpose: types for the asynchronous memory controller
// Assumes: constants come from async_mem_params.svh
// Notes:   config fields store count - 1
`include "async_mem_params.svh"

package async_mem_pkg;

  // per chip-select timing and mode setup
  typedef struct packed {
    logic [`AM_TA_W-1:0]     turnaround_cycles;
    logic [`AM_SETUP_W-1:0]  read_setup_cycles;
    logic [`AM_STROBE_W-1:0] read_strobe_cycles;
    logic [`AM_HOLD_W-1:0]   read_hold_cycles;
    logic [`AM_SETUP_W-1:0]  write_setup_cycles;
    logic [`AM_STROBE_W-1:0] write_strobe_cycles;
    logic [`AM_HOLD_W-1:0]   write_hold_cycles;
    logic                    extended_wait_enable;
    logic                    select_strobe_mode;
    logic                    wide_bus;
  } bank_cfg_t;

  // one access request
  typedef struct packed {
    logic                   write;
    logic [`AM_CS_W-1:0]    chip;
    logic [`AM_BANK_W-1:0]  bank;
    logic [`AM_ADDR_W-1:0]  addr;
    logic [`AM_DATA_W-1:0]  wdata;
  } mem_req_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_EXTEND,
    ST_RELEASE,
    ST_HOLD,
    ST_TURN
  } phase_t;

endpackage

// [design/async_mem_ctrl.sv]
// Purpose: paces asynchronous SRAM/flash accesses in setup, strobe, hold and turnaround phases
// Assumes: one clock (interface clock); ext_wait_n and ext_data pass two flops before use
// Notes:   chip selects, strobes and data bus are driven from flops; bus parks when idle
`timescale 1ns/1ps

module async_mem_ctrl
  import async_mem_pkg::*;
#(
  parameter int NUM_CS = `AM_NUM_CS,
  parameter int DATA_W = `AM_DATA_W
)
(
  input  wire logic                                 i_ref_clk,
  input  wire logic                                 i_nrst,
  input  wire async_mem_pkg::bank_cfg_t             i_bank_cfg [NUM_CS],
  input  wire logic [`AM_MAXWAIT_W-1:0]             i_max_wait_cycles,
  input  wire logic                                 i_req_valid,
  input  wire async_mem_pkg::mem_req_t              i_req,
  output logic                                      o_req_ready,
  output logic                                      o_done,
  output logic                                      o_timeout,
  output logic [DATA_W-1:0]                         o_rdata,
  output logic [NUM_CS-1:0]                         o_async_chip_select_n,
  output logic                                      o_output_enable_n,
  output logic                                      o_write_enable_n,
  output logic [`AM_ADDR_W-1:0]                     o_ext_address,
  output logic [`AM_BANK_W-1:0]                     o_bank_address,
  input  wire logic [DATA_W-1:0]                    i_ext_data,
  output logic [DATA_W-1:0]                         o_ext_data,
  output logic                                      o_ext_data_oe,
  input  wire logic                                 i_ext_wait_n
);
  import async_mem_pkg::*;

  // the logic serves exactly the documented pin set
  if (NUM_CS != `AM_NUM_CS || DATA_W != `AM_DATA_W)
  begin : g_check
    $error("async_mem_ctrl: NUM_CS must be 3 and DATA_W 16");
  end

  // the phase counter must hold the widest programmed field
  if (`AM_CNT_W < `AM_STROBE_W || `AM_CNT_W < `AM_SETUP_W || `AM_CNT_W < `AM_HOLD_W || `AM_CNT_W < `AM_TA_W)
  begin : g_cnt_check
    $error("async_mem_ctrl: phase counter narrower than a phase field");
  end

  // one wait unit is exactly one full turn of the sub-counter
  if ((1 << `AM_WSUB_W) != `AM_WAIT_UNIT)
  begin : g_unit_check
    $error("async_mem_ctrl: wait sub-counter does not span one wait unit");
  end

  // the unit ends on the sub-counter's top value
  if (`AM_WSUB_LAST != `AM_WAIT_UNIT - 1)
  begin : g_last_check
    $error("async_mem_ctrl: last sub-count does not close the wait unit");
  end

  // at least one release period keeps the strobe end on a phase edge
  if (`AM_RELEASE_CYC < 1)
  begin : g_release_check
    $error("async_mem_ctrl: release phase must last one period or more");
  end

  // the chip field must be able to name every select
  if ((1 << `AM_CS_W) < NUM_CS)
  begin : g_chip_check
    $error("async_mem_ctrl: chip field too narrow for the select count");
  end

  phase_t                   state;
  phase_t                   next_state;
  logic [`AM_CNT_W-1:0]     cnt;
  logic [`AM_CNT_W-1:0]     next_cnt;
  mem_req_t                 req;
  bank_cfg_t                cfg;
  logic                     wait_n_s1;
  logic                     wait_n_s2;
  logic [DATA_W-1:0]        data_s1;
  logic [DATA_W-1:0]        data_s2;
  logic [`AM_WSUB_W-1:0]    wsub;
  logic [`AM_MAXWAIT_W-1:0] wait_cycle_count;
  logic                     wait_limit;
  logic                     accept;
  logic                     strobe_phase;
  logic                     next_strobe;
  logic                     next_active;

  // config of the access in flight; in idle look ahead to the incoming one
  // config is read live, so software changes it only while the controller is idle
  assign cfg    = i_bank_cfg[(state == ST_IDLE) ? i_req.chip : req.chip];
  assign accept = i_req_valid && o_req_ready && (i_req.chip < `AM_CS_W'(NUM_CS));

  // limit hit after max_wait_cycles + 1 full units of sixteen periods
  assign wait_limit = (wait_cycle_count == i_max_wait_cycles) && (wsub == `AM_WSUB_LAST);

  assign strobe_phase = (state == ST_STROBE) || (state == ST_EXTEND) || (state == ST_RELEASE);
  assign next_strobe  = (next_state == ST_STROBE) || (next_state == ST_EXTEND) || (next_state == ST_RELEASE);
  assign next_active  = next_strobe || (next_state == ST_SETUP) || (next_state == ST_HOLD);

  // two-flop synchronisers for the wait pin and the read data bus
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      wait_n_s1 <= 1'b1;
      wait_n_s2 <= 1'b1;
      data_s1   <= `AM_DATA_RST;
      data_s2   <= `AM_DATA_RST;
    end
    else
    begin
      wait_n_s1 <= i_ext_wait_n;
      wait_n_s2 <= wait_n_s1;
      data_s1   <= i_ext_data;
      data_s2   <= data_s1;
    end
  end

  // phase sequencer: counts load count-1, so a field of n gives n+1 periods
  always_comb
  begin
    next_state = state;
    next_cnt   = cnt - `AM_CNT_W'(1);
    unique case (state)
      ST_IDLE:
      begin
        next_cnt = `AM_CNT_ZERO;
        if (accept)
        begin
          next_state = ST_SETUP;
          next_cnt   = i_req.write ? `AM_CNT_W'(cfg.write_setup_cycles)
                                   : `AM_CNT_W'(cfg.read_setup_cycles);
        end
      end
      ST_SETUP:
        if (cnt == `AM_CNT_ZERO)
        begin
          next_state = ST_STROBE;
          next_cnt   = req.write ? cfg.write_strobe_cycles : cfg.read_strobe_cycles;
        end
      ST_STROBE:
        if (cnt == `AM_CNT_ZERO)
        begin
          // wait must already be seen here, which the far side's lead time guarantees
          if (cfg.extended_wait_enable && !wait_n_s2)
          begin
            next_state = ST_EXTEND;
            next_cnt   = `AM_CNT_ZERO;
          end
          else
          begin
            next_state = ST_HOLD;
            next_cnt   = req.write ? `AM_CNT_W'(cfg.write_hold_cycles)
                                   : `AM_CNT_W'(cfg.read_hold_cycles);
          end
        end
      ST_EXTEND:
      begin
        next_cnt = `AM_CNT_ZERO;
        if (wait_n_s2)
        begin
          // two sync flops, this decision edge and one release period: strobe ends 4 periods after the pin
          next_state = ST_RELEASE;
          next_cnt   = `AM_CNT_W'(`AM_RELEASE_CYC - 1);
        end
        else if (wait_limit)
        begin
          next_state = ST_HOLD;
          next_cnt   = req.write ? `AM_CNT_W'(cfg.write_hold_cycles)
                                 : `AM_CNT_W'(cfg.read_hold_cycles);
        end
      end
      ST_RELEASE:
        if (cnt == `AM_CNT_ZERO)
        begin
          next_state = ST_HOLD;
          next_cnt   = req.write ? `AM_CNT_W'(cfg.write_hold_cycles)
                                 : `AM_CNT_W'(cfg.read_hold_cycles);
        end
      ST_HOLD:
        if (cnt == `AM_CNT_ZERO)
        begin
          next_state = ST_TURN;
          next_cnt   = `AM_CNT_W'(cfg.turnaround_cycles);
        end
      ST_TURN:
        if (cnt == `AM_CNT_ZERO)
        begin
          next_state = ST_IDLE;
          next_cnt   = `AM_CNT_ZERO;
        end
    endcase
  end

  // state and phase counter
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state <= ST_IDLE;
      cnt   <= `AM_CNT_ZERO;
    end
    else
    begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // request latch, held stable for the whole access
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      req <= '0;
    else if (accept)
      req <= i_req;
  end

  // extended wait counter in units of sixteen interface periods
  // the extension ends on the pin, so its length is wait time plus release, not a multiple of sixteen
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      wsub             <= '0;
      wait_cycle_count <= '0;
    end
    else if (state != ST_EXTEND)
    begin
      wsub             <= '0;
      wait_cycle_count <= '0;
    end
    else
    begin
      wsub <= wsub + `AM_WSUB_W'(1);
      if (wsub == `AM_WSUB_LAST)
        wait_cycle_count <= wait_cycle_count + `AM_MAXWAIT_W'(1);
    end
  end

  // chip select and strobes, registered from the next phase so pins change on phase edges
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_async_chip_select_n <= `AM_CS_IDLE;
      o_output_enable_n     <= 1'b1;
      o_write_enable_n      <= 1'b1;
    end
    else
    begin
      o_async_chip_select_n <= `AM_CS_IDLE;
      // select strobe mode drops the select only with the strobe itself
      if (cfg.select_strobe_mode ? next_strobe : next_active)
        o_async_chip_select_n[(state == ST_IDLE) ? i_req.chip : req.chip] <= 1'b0;
      o_output_enable_n <= !(next_strobe && !req.write);
      o_write_enable_n  <= !(next_strobe && req.write);
    end
  end

  // address and bank load on accept and park between accesses
  // parking avoids needless address toggling between accesses
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_ext_address  <= `AM_ADDR_RST;
      o_bank_address <= `AM_BANK_RST;
    end
    else if (accept)
    begin
      o_ext_address  <= i_req.addr;
      o_bank_address <= i_req.bank;
    end
  end

  // data bus: write data on accept, released only while a read strobe runs
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_ext_data    <= `AM_DATA_RST;
      o_ext_data_oe <= 1'b1;
    end
    else
    begin
      if (accept && i_req.write)
        o_ext_data <= cfg.wide_bus ? i_req.wdata : {{(DATA_W-`AM_BYTE_W){1'b0}}, i_req.wdata[`AM_BYTE_W-1:0]};
      o_ext_data_oe <= !(next_strobe && !req.write);
    end
  end

  // read capture as the strobe closes; data seen through the synchroniser lags two periods
  // limitation: the memory must drive valid data two periods before the strobe ends
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_rdata <= `AM_DATA_RST;
    else if (strobe_phase && (next_state == ST_HOLD) && !req.write)
      o_rdata <= cfg.wide_bus ? data_s2 : {{(DATA_W-`AM_BYTE_W){1'b0}}, data_s2[`AM_BYTE_W-1:0]};
  end

  // handshake and status
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_req_ready <= 1'b1;
      o_done      <= 1'b0;
      o_timeout   <= 1'b0;
    end
    else
    begin
      o_req_ready <= (next_state == ST_IDLE);
      o_done      <= (state == ST_HOLD) && (next_state == ST_TURN);
      if (accept)
        o_timeout <= 1'b0;
      else if ((state == ST_EXTEND) && !wait_n_s2 && wait_limit)
        o_timeout <= 1'b1;
    end
  end

endmodule

// [sim/async_mem_ctrl_properties.sv]
// Purpose: pin timing checks for the async memory controller
// Assumes: config changes only while the controller is idle
// Notes:   counters measure phases from the taking edge and strobe edges
`timescale 1ns/1ps
module async_mem_ctrl_properties
  import async_mem_pkg::*;
#(
  parameter int NUM_CS = 3
)
(
  input wire logic                     i_ref_clk,
  input wire logic                     i_nrst,
  input wire async_mem_pkg::bank_cfg_t i_bank_cfg [NUM_CS],
  input wire logic                     i_req_valid,
  input wire async_mem_pkg::mem_req_t  i_req,
  input wire logic                     o_req_ready,
  input wire logic                     o_done,
  input wire logic [NUM_CS-1:0]        o_async_chip_select_n,
  input wire logic                     o_output_enable_n,
  input wire logic                     o_write_enable_n,
  input wire logic [21:0]              o_ext_address,
  input wire logic [1:0]               o_bank_address,
  input wire logic                     o_ext_data_oe,
  input wire logic                     i_ext_wait_n
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  bank_cfg_t   cfg;
  logic [1:0]  chip;
  logic        wr, stb_n, cs_lo;
  logic [23:0] bank_addr;
  logic [12:0] acc_cnt, lo_cnt, hi_cnt, s_n, t_n, h_n, ta_n;
  // programmed phase lengths of the access in flight
  assign cfg   = i_bank_cfg[chip];
  assign stb_n = o_output_enable_n & o_write_enable_n;
  assign cs_lo = ~&o_async_chip_select_n;
  assign s_n   = 13'(wr ? cfg.write_setup_cycles : cfg.read_setup_cycles) + 13'h1;
  assign t_n   = 13'(wr ? cfg.write_strobe_cycles : cfg.read_strobe_cycles) + 13'h1;
  assign h_n   = 13'(wr ? cfg.write_hold_cycles : cfg.read_hold_cycles) + 13'h1;
  assign ta_n  = 13'(cfg.turnaround_cycles) + 13'h1;
  // acc_cnt and hi_cnt saturate so a stalled run cannot wrap into a false match
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      {chip, wr, bank_addr, acc_cnt, lo_cnt, hi_cnt} <= '0;
    end
    else
    begin
      if (i_req_valid && o_req_ready && i_req.chip != 2'h3)
      begin
        {chip, wr, bank_addr} <= {i_req.chip, i_req.write, i_req.bank, i_req.addr};
        acc_cnt <= 13'h0;
      end
      else
        acc_cnt <= acc_cnt + {12'h0, acc_cnt != 13'h1fff};
      lo_cnt <= stb_n ? 13'h0 : lo_cnt + 13'h1;
      hi_cnt <= stb_n ? hi_cnt + {12'h0, hi_cnt != 13'h1fff} : 13'h0;
    end
  end
  property p_setup; $fell(stb_n) |-> acc_cnt == s_n; endproperty
  a_setup: assert property (p_setup) else $error("setup length wrong");
  property p_sel; cfg.select_strobe_mode |-> cs_lo == !stb_n; endproperty
  a_sel: assert property (p_sel) else $error("select not tracking strobe");
  property p_hold; $fell(cs_lo) && !cfg.select_strobe_mode |-> hi_cnt == h_n; endproperty
  a_hold: assert property (p_hold) else $error("select hold wrong");
  property p_width; $rose(stb_n) && !cfg.extended_wait_enable |-> lo_cnt == t_n; endproperty
  a_width: assert property (p_width) else $error("strobe width wrong");
  property p_cycle; o_done && !cfg.extended_wait_enable |-> acc_cnt == s_n + t_n + h_n; endproperty
  a_cycle: assert property (p_cycle) else $error("cycle length wrong");
  property p_turn; $rose(o_req_ready) |-> hi_cnt == h_n + ta_n; endproperty
  a_turn: assert property (p_turn) else $error("turnaround wrong");
  property p_addr; $fell(stb_n) |-> {o_bank_address, o_ext_address} == bank_addr; endproperty
  a_addr: assert property (p_addr) else $error("address not valid at strobe");
  property p_bus; o_ext_data_oe == o_output_enable_n; endproperty
  a_bus: assert property (p_bus) else $error("data bus released outside read strobe");
  property p_wait; $rose(i_ext_wait_n) && !stb_n && lo_cnt > t_n |-> ##[3:4] stb_n; endproperty
  a_wait: assert property (p_wait) else $error("strobe late after wait release");
endmodule

// [sim/async_sram_model.sv]
// Purpose: far-side async memory with a programmable wait stretch
// Assumes: 16 words indexed by the low address bits
// Notes:   released data lines show the inverse of the last value
`timescale 1ns/1ps
module async_sram_model
(
  input  wire logic        i_ref_clk,
  input  wire logic [2:0]  i_cs_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  input  wire logic [21:0] i_addr,
  input  wire logic [15:0] i_data,
  input  wire logic [7:0]  i_stretch,
  output logic      [15:0] o_data,
  output logic             o_wait_n
);
  logic [15:0] mem [16];
  logic [15:0] last = 16'h0;
  logic [7:0]  left = 8'h0;
  logic        sel;
  logic        seen = 1'b0;
  // drive only while selected and read-enabled, so a stale bus never looks valid
  assign sel = ~&i_cs_n;
  assign o_data = (sel && !i_oe_n) ? mem[i_addr[3:0]] : ~last;
  assign o_wait_n = (left == 8'h0);
  // store while select and write strobe are low; wait starts one period after the strobe
  always @(posedge i_ref_clk)
  begin
    if (sel && !i_we_n) mem[i_addr[3:0]] <= i_data;
    if (sel && !i_oe_n) last <= mem[i_addr[3:0]];
    if (left != 8'h0) left <= left - 8'h1; // held low for the stretch, bench sets it to 0 (no wait), 20 or 200
    else if (!(i_oe_n & i_we_n) && !seen) left <= i_stretch; // asserted one period after strobe start, well ahead
    seen <= !(i_oe_n & i_we_n);
  end
endmodule

// [sim/async_mem_ctrl_bench.sv]
// Purpose: directed bench for the async memory controller
// Assumes: far-side model answers with a programmable wait
// Notes:   inputs change on the falling edge; config only while idle
`timescale 1ns/1ps
module async_mem_ctrl_bench;
  import async_mem_pkg::*;
  logic        i_ref_clk = 1'b0;
  logic        i_nrst = 1'b0;
  logic        valid = 1'b0;
  logic        ready, done, tmo, oe_n, we_n, doe, wait_n;
  logic [7:0]  max_w = 8'h3;
  logic [7:0]  stretch = 8'h0;
  logic [2:0]  cs_n;
  logic [15:0] rdata, dout, din;
  logic [21:0] addr;
  logic [1:0]  bank;
  logic [31:0] len;
  bank_cfg_t   cfg [3];
  mem_req_t    req = '0;
  int          n_errors = 0;
  int          check_count = 0;
  always #4 i_ref_clk = ~i_ref_clk;
  async_mem_ctrl dut_u (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_bank_cfg(cfg), .i_max_wait_cycles(max_w),
    .i_req_valid(valid), .i_req(req), .o_req_ready(ready), .o_done(done), .o_timeout(tmo), .o_rdata(rdata),
    .o_async_chip_select_n(cs_n), .o_output_enable_n(oe_n), .o_write_enable_n(we_n), .o_ext_address(addr),
    .o_bank_address(bank), .i_ext_data(din), .o_ext_data(dout), .o_ext_data_oe(doe), .i_ext_wait_n(wait_n));
  async_sram_model mem_u (.i_ref_clk(i_ref_clk), .i_cs_n(cs_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_addr(addr),
    .i_data(dout), .i_stretch(stretch), .o_data(din), .o_wait_n(wait_n));
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // nominal setup plus strobe plus hold, fields hold count minus one
  function automatic logic [31:0] dur(input bank_cfg_t c, input logic w);
    return w ? c.write_setup_cycles + c.write_strobe_cycles + c.write_hold_cycles + 32'h3
             : c.read_setup_cycles + c.read_strobe_cycles + c.read_hold_cycles + 32'h3;
  endfunction
  // offer one request while idle, count periods to the done pulse, then wait out the turnaround
  task automatic access(input logic w, input logic [1:0] c, input logic [15:0] d);
    @(negedge i_ref_clk);
    req = '{w, c, c, 22'h3ffff0 + 22'(c), d};
    valid = 1'b1;
    @(negedge i_ref_clk);
    valid = 1'b0;
    len = 32'h0;
    while (done !== 1'b1)
    begin
      @(negedge i_ref_clk);
      len++;
      if (len > 32'h1000)
      begin
        n_errors++;
        tally_and_finish();
      end
    end
    repeat (6) if (ready !== 1'b1) @(negedge i_ref_clk);
    check(ready, 1'b1, "ready after turnaround");
    @(negedge i_ref_clk);
  endtask
  initial
  begin
    cfg[0] = '{2'h0, 4'h0, 6'h3, 3'h0, 4'h0, 6'h0, 3'h0, 1'b0, 1'b0, 1'b1};
    cfg[1] = '{2'h3, 4'hf, 6'h3f, 3'h7, 4'hf, 6'h3f, 3'h7, 1'b0, 1'b1, 1'b1};
    cfg[2] = '{2'h1, 4'h2, 6'h4, 3'h2, 4'h1, 6'h3, 3'h1, 1'b0, 1'b0, 1'b0};
    repeat (10) @(negedge i_ref_clk);
    i_nrst = 1'b1;
    check({cs_n, oe_n, we_n, doe, ready, done, tmo}, 9'h1fc, "idle pins");
    req.chip = 2'h3;
    valid = 1'b1;
    repeat (4) @(negedge i_ref_clk);
    valid = 1'b0;
    check({ready, cs_n}, 4'hf, "fourth select ignored");
    // every select: minimum, maximum and mixed timings, wide and narrow bus
    for (int c = 0; c < 3; c++)
    begin
      access(1'b1, 2'(c), 16'ha5c3 ^ 16'(c));
      check(len, dur(cfg[c], 1'b1), "write length");
      access(1'b0, 2'(c), 16'h0);
      check(len, dur(cfg[c], 1'b0), "read length");
      check(rdata, cfg[c].wide_bus ? 16'ha5c3 ^ 16'(c) : 16'h00c3 ^ 16'(c), "read data");
    end
    // stretched accesses, then a wait that outlasts the limit
    cfg[0].extended_wait_enable = 1'b1;
    cfg[0].read_strobe_cycles = 6'h7;
    cfg[0].write_strobe_cycles = 6'h7;
    stretch = 8'h14;
    // strobe: one period until the model asserts wait, the stretch, four to release, instead of eight nominal
    access(1'b1, 2'h0, 16'h1234);
    check(len, dur(cfg[0], 1'b1) + 32'(stretch) - 32'h3, "write stretched");
    access(1'b0, 2'h0, 16'h0);
    check(len, dur(cfg[0], 1'b0) + 32'(stretch) - 32'h3, "read stretched");
    check({tmo, rdata}, 17'h01234, "stretched read");
    max_w = 8'h0;
    stretch = 8'hc8;
    access(1'b0, 2'h0, 16'h0);
    check(tmo, 1'b1, "wait limit");
    check(len, dur(cfg[0], 1'b0) + 32'h10, "wait limit length");
    repeat (200) @(negedge i_ref_clk);
    stretch = 8'h0;
    access(1'b0, 2'h0, 16'h0);
    check({tmo, rdata}, 17'h01234, "timeout cleared");
    tally_and_finish();
  end
endmodule

bind async_mem_ctrl async_mem_ctrl_properties #(.NUM_CS(NUM_CS)) chk_u (
  .i_ref_clk             (i_ref_clk),
  .i_nrst                (i_nrst),
  .i_bank_cfg            (i_bank_cfg),
  .i_req_valid           (i_req_valid),
  .i_req                 (i_req),
  .o_req_ready           (o_req_ready),
  .o_done                (o_done),
  .o_async_chip_select_n (o_async_chip_select_n),
  .o_output_enable_n     (o_output_enable_n),
  .o_write_enable_n      (o_write_enable_n),
  .o_ext_address         (o_ext_address),
  .o_bank_address        (o_bank_address),
  .o_ext_data_oe         (o_ext_data_oe),
  .i_ext_wait_n          (i_ext_wait_n)
);
